// ===== design/ttc_pkg.sv
// How it works
// - when the last octet of a received frame arrives, its octet count is loaded into last_frame_length and never written to the frame buffer.
// - gain_loop_control takes writes only while power_management_enable is set, otherwise it holds its reset value.
// - modulator_override takes writes only while power_management_enable is set, otherwise it holds its reset value.
// - gain bit 5 at one disables the baseband gain hold function, at zero gain control runs normally.
// - gain bit 4 at one forces the gain code to zero, the maximum gain.
// - gain bit 3 at zero lets the automatic regulation choose the gain, at one the manual gain code is used.
// - gain bit 2 at zero lets the gain loop run free, at one puts it in hold mode.
// - the gain code field reads back the gain in use and takes manual writes; 0 maximum, 1 medium, 2 and 3 minimum.
// - modulator bit 7 at zero feeds chips from transmit memory, at one feeds a constant chip stream.
// - with the constant stream chosen, modulator bit 6 gives all zero chips or all one chips.
// - modulator bit 5 picks the receive path at zero and the transmit path at one.
// - modulator bit 4 at zero leaves the path to the transceiver state machine, at one to bit 5.
// - a 128 byte frame buffer is exposed, first byte at the buffer start register, last at the buffer end register.
package ttc_pkg;
    // apb byte address width; register index is paddr[10:2]
    localparam int ADDR_W = 12;
    localparam int IDX_W = 9;
    // register word indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL_ZERO = 9'h170;
    localparam logic [IDX_W-1:0] IDX_LAST_FRAME_LENGTH = 9'h17b;
    localparam logic [IDX_W-1:0] IDX_GAIN_LOOP_CONTROL = 9'h17c;
    localparam logic [IDX_W-1:0] IDX_MODULATOR_OVERRIDE = 9'h17d;
    localparam logic [IDX_W-1:0] IDX_FBUF_FIRST = 9'h180;
    localparam logic [IDX_W-1:0] IDX_FBUF_LAST = 9'h1ff;
    localparam int FBUF_DEPTH = 128;
    localparam int FBUF_AW = 7;
    // field positions
    localparam int PME_BIT = 0;
    localparam int HOLD_DIS_BIT = 5;
    localparam int FORCE_MAX_BIT = 4;
    localparam int LOOP_DIS_BIT = 3;
    localparam int HOLD_MODE_BIT = 2;
    localparam int GAIN_CODE_LSB = 0;
    localparam int CHIP_SRC_BIT = 7;
    localparam int CHIP_LEVEL_BIT = 6;
    localparam int PATH_BIT = 5;
    localparam int PATH_SEL_BIT = 4;
    // reset values and masks
    localparam logic [7:0] CTRL_ZERO_RST = 8'h00;
    localparam logic [7:0] LEN_RST = 8'h00;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [7:0] OVR_RST = 8'h00;
    localparam logic [7:0] CTRL_ZERO_MASK = 8'h01;
    localparam logic [7:0] GAIN_WR_MASK = 8'h3f;
    localparam logic [1:0] GAIN_CODE_MAX = 2'h0;
    localparam logic [7:0] RX_CNT_RST = 8'h00;
endpackage : ttc_pkg

// ===== design/ttc_regs.sv
`timescale 1ns/1ns
module ttc_regs
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ttc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receiver octet stream, same clock
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_last,
    // gain loop
    input wire logic [1:0] agc_auto_code,
    output logic [1:0] gain_code_out,
    output logic hold_function_disable,
    output logic gain_force_max,
    output logic gain_loop_disable,
    output logic gain_hold_mode,
    // modulator
    input wire logic tx_ram_chip,
    input wire logic fsm_path_tx,
    output logic modulator_chip,
    output logic chip_source_select,
    output logic modulator_path_tx,
    // power management
    output logic power_management_enable
);
    import ttc_pkg::*;

    logic [7:0] ctrl_zero_reg;
    logic [7:0] ctrl_zero_next;
    logic [7:0] len_reg;
    logic [7:0] len_next;
    logic [7:0] rx_cnt_reg;
    logic [7:0] rx_cnt_next;
    logic [7:0] gain_reg;
    logic [7:0] gain_next;
    logic [7:0] ovr_reg;
    logic [7:0] ovr_next;
    logic [1:0] gain_code_reg;
    logic [1:0] gain_code_next;
    logic chip_reg;
    logic chip_next;
    logic path_reg;
    logic path_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [7:0] fbuf [FBUF_DEPTH];
    logic fb_we;
    logic [FBUF_AW-1:0] fb_waddr;
    logic [7:0] fb_wdata;
    logic [IDX_W-1:0] idx;
    logic in_range;
    logic hit_ctrl;
    logic hit_len;
    logic hit_gain;
    logic hit_ovr;
    logic hit_fbuf;
    logic mapped;
    logic setup;
    logic wr_go;
    logic rx_take;
    logic [FBUF_AW-1:0] fb_raddr;
    logic [7:0] fb_rbyte;
    logic pme;

    // address decode, low two address bits ignored
    assign idx = paddr[10:2];
    assign in_range = ~paddr[ADDR_W-1];
    assign hit_ctrl = in_range && (idx == IDX_CTRL_ZERO);
    assign hit_len = in_range && (idx == IDX_LAST_FRAME_LENGTH);
    assign hit_gain = in_range && (idx == IDX_GAIN_LOOP_CONTROL);
    assign hit_ovr = in_range && (idx == IDX_MODULATOR_OVERRIDE);
    assign hit_fbuf = in_range && (idx >= IDX_FBUF_FIRST) && (idx <= IDX_FBUF_LAST);
    assign mapped = hit_ctrl | hit_len | hit_gain | hit_ovr | hit_fbuf;
    assign fb_raddr = idx[FBUF_AW-1:0] - IDX_FBUF_FIRST[FBUF_AW-1:0];
    assign fb_rbyte = fbuf[fb_raddr];

    // read data is sampled in setup, so access closes in one cycle while pce is high
    assign setup = psel && !penable;
    assign pready = psel && penable && pce;
    assign pslverr = pready && !mapped;
    assign wr_go = pready && pwrite && pstrb[0];
    assign prdata = prdata_reg;
    assign rx_take = rx_byte_valid && pce;
    assign pme = ctrl_zero_reg[PME_BIT];

    // readback mux; reserved gain bits read zero
    always_comb
    begin
        prdata_next = prdata_reg;
        if (setup && !pwrite)
        begin
            prdata_next = 32'h0000_0000;
            if (hit_ctrl)
                prdata_next[7:0] = ctrl_zero_reg;
            if (hit_len)
                prdata_next[7:0] = len_reg;
            if (hit_gain)
                prdata_next[7:0] = {gain_reg[7:2], gain_code_reg};
            if (hit_ovr)
                prdata_next[7:0] = ovr_reg;
            if (hit_fbuf)
                prdata_next[7:0] = fb_rbyte;
        end
    end

    // register writes; gain and modulator drop to reset while pme is low
    always_comb
    begin
        ctrl_zero_next = ctrl_zero_reg;
        gain_next = gain_reg;
        ovr_next = ovr_reg;
        if (wr_go && hit_ctrl)
            ctrl_zero_next = pwdata[7:0] & CTRL_ZERO_MASK;
        if (!pme)
            gain_next = GAIN_RST;
        else if (wr_go && hit_gain)
            gain_next = pwdata[7:0] & GAIN_WR_MASK;
        if (!pme)
            ovr_next = OVR_RST;
        else if (wr_go && hit_ovr)
            ovr_next = pwdata[7:0];
    end

    // receive side: octets fill the buffer from byte 0, length kept apart
    always_comb
    begin
        len_next = len_reg;
        rx_cnt_next = rx_cnt_reg;
        fb_we = 1'b0;
        fb_waddr = rx_cnt_reg[FBUF_AW-1:0];
        fb_wdata = rx_byte;
        if (rx_take)
        begin
            fb_we = !rx_cnt_reg[FBUF_AW];
            if (rx_byte_last)
            begin
                len_next = rx_cnt_reg + 8'h01;
                rx_cnt_next = RX_CNT_RST;
            end
            else if (rx_cnt_reg != 8'hff)
                rx_cnt_next = rx_cnt_reg + 8'h01;
        end
        else if (wr_go && hit_fbuf)
        begin
            // receiver wins a same-cycle clash; software byte is lost
            fb_we = 1'b1;
            fb_waddr = fb_raddr;
            fb_wdata = pwdata[7:0];
        end
    end

    // effective gain code and modulator drive
    always_comb
    begin
        if (gain_reg[FORCE_MAX_BIT])
            gain_code_next = GAIN_CODE_MAX;
        else if (gain_reg[LOOP_DIS_BIT])
            gain_code_next = gain_reg[GAIN_CODE_LSB +: 2];
        else
            gain_code_next = agc_auto_code;
        chip_next = ovr_reg[CHIP_SRC_BIT] ? ovr_reg[CHIP_LEVEL_BIT] : tx_ram_chip;
        path_next = ovr_reg[PATH_SEL_BIT] ? ovr_reg[PATH_BIT] : fsm_path_tx;
    end

    // control state, frozen while pce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_zero_reg <= CTRL_ZERO_RST;
            gain_reg <= GAIN_RST;
            ovr_reg <= OVR_RST;
            len_reg <= LEN_RST;
            rx_cnt_reg <= RX_CNT_RST;
            gain_code_reg <= GAIN_CODE_MAX;
            chip_reg <= 1'b0;
            path_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else if (pce)
        begin
            ctrl_zero_reg <= ctrl_zero_next;
            gain_reg <= gain_next;
            ovr_reg <= ovr_next;
            len_reg <= len_next;
            rx_cnt_reg <= rx_cnt_next;
            gain_code_reg <= gain_code_next;
            chip_reg <= chip_next;
            path_reg <= path_next;
            prdata_reg <= prdata_next;
        end
    end

    // buffer storage has no reset; contents are data, not control
    always_ff @(posedge pclk)
    begin
        if (fb_we)
            fbuf[fb_waddr] <= fb_wdata;
    end

    // outputs straight from flip-flops
    assign power_management_enable = pme;
    assign hold_function_disable = gain_reg[HOLD_DIS_BIT];
    assign gain_force_max = gain_reg[FORCE_MAX_BIT];
    assign gain_loop_disable = gain_reg[LOOP_DIS_BIT];
    assign gain_hold_mode = gain_reg[HOLD_MODE_BIT];
    assign gain_code_out = gain_code_reg;
    assign chip_source_select = ovr_reg[CHIP_SRC_BIT];
    assign modulator_chip = chip_reg;
    assign modulator_path_tx = path_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // length loads one past the count on the final octet
    AST_LEN_ON_LAST: assert property (rx_take && rx_byte_last |=>
        len_reg == $past(rx_cnt_reg) + 8'h01)
        else $error("length not loaded on final octet");
    // length stays put while no frame ends
    AST_LEN_STABLE: assert property (pce && !(rx_byte_valid && rx_byte_last) |=>
        $stable(len_reg))
        else $error("length changed without frame end");
    // gain register held at reset while pme is low
    AST_GAIN_PME_OFF: assert property (pce && !pme |=> gain_reg == GAIN_RST)
        else $error("gain setting active without pme");
    // modulator register held at reset while pme is low
    AST_OVR_PME_OFF: assert property (pce && !pme |=> ovr_reg == OVR_RST)
        else $error("modulator setting active without pme");
    // hold disable follows a granted write
    AST_HOLD_DIS: assert property (wr_go && hit_gain && pme |=>
        hold_function_disable == $past(pwdata[HOLD_DIS_BIT]))
        else $error("hold disable did not follow write");
    // force max drives code zero next cycle
    AST_FORCE_MAX: assert property (pce && gain_force_max |=> gain_code_out == GAIN_CODE_MAX)
        else $error("forced gain not maximum");
    // manual code used when regulation is off
    AST_MANUAL_CODE: assert property (pce && !gain_force_max && gain_loop_disable |=>
        gain_code_out == $past(gain_reg[1:0]))
        else $error("manual gain code not applied");
    // automatic code used when regulation is on
    AST_AUTO_CODE: assert property (pce && !gain_force_max && !gain_loop_disable |=>
        gain_code_out == $past(agc_auto_code))
        else $error("automatic gain code not followed");
    // hold mode follows a granted write
    AST_HOLD_MODE: assert property (wr_go && hit_gain && pme |=>
        gain_hold_mode == $past(pwdata[HOLD_MODE_BIT]))
        else $error("hold mode did not follow write");
    // chip source and level
    AST_CHIP_SRC: assert property (pce |=> modulator_chip ==
        ($past(ovr_reg[CHIP_SRC_BIT]) ? $past(ovr_reg[CHIP_LEVEL_BIT]) : $past(tx_ram_chip)))
        else $error("modulator chip from wrong source");
    // path owner
    AST_PATH: assert property (pce |=> modulator_path_tx ==
        ($past(ovr_reg[PATH_SEL_BIT]) ? $past(ovr_reg[PATH_BIT]) : $past(fsm_path_tx)))
        else $error("modulator path from wrong owner");
    // buffer readback returns the indexed byte
    AST_FBUF_READ: assert property (pce && setup && !pwrite && hit_fbuf |=>
        prdata == {24'h00_0000, $past(fb_rbyte)})
        else $error("buffer read returned wrong byte");
    // one-cycle access phase
    AST_ONE_WAIT: assert property (pce && setup ##1 pce && psel && penable |-> pready)
        else $error("access phase not answered");
    // software buffer write lands at its index when the receiver is idle
    AST_FBUF_WRITE: assert property (wr_go && hit_fbuf && !rx_take |=>
        fbuf[$past(fb_raddr)] == $past(pwdata[7:0]))
        else $error("buffer write did not land");
    // received octet n lands at buffer byte n
    AST_RX_STORE: assert property (rx_take && !rx_cnt_reg[FBUF_AW] |=>
        fbuf[$past(rx_cnt_reg[FBUF_AW-1:0])] == $past(rx_byte))
        else $error("received octet not stored");
    // power management enable follows a granted write
    AST_PME_WRITE: assert property (wr_go && hit_ctrl |=>
        pme == $past(pwdata[PME_BIT]))
        else $error("power management enable did not follow write");
    // unmapped reads return zero, so no stale data leaks out
    AST_UNMAPPED_READ: assert property (pce && setup && !pwrite && !mapped |=>
        prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    // reserved gain bits never hold a one, whatever software writes
    AST_GAIN_RSVD: assert property (pce |=> gain_reg[7:6] == 2'h0)
        else $error("reserved gain bits set");

    COV_FRAME: cover property (rx_take && rx_byte_last);
    COV_FORCE_MAX: cover property (pme && gain_force_max);
    COV_MANUAL_GAIN: cover property (pme && gain_loop_disable && !gain_force_max);
    COV_FIXED_ONES: cover property (chip_source_select && modulator_chip);
    COV_FBUF_END: cover property (pready && idx == IDX_FBUF_LAST);
endmodule : ttc_regs

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    import ttc_pkg::*;
    // bench-driven inputs, all given a value at time zero
    logic pclk = 0, presetn = 0, pce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, err, tx_ram_chip = 0, fsm_path_tx = 0;
    logic rx_byte_valid = 0, rx_byte_last = 0;
    logic [7:0] rx_byte = '0;
    logic [1:0] agc_auto_code = '0, gain_code_out;
    logic hold_function_disable, gain_force_max, gain_loop_disable, gain_hold_mode;
    logic modulator_chip, chip_source_select, modulator_path_tx, power_management_enable;
    int miscompares = 0, cmp_count = 0, cycles = 0;

    ttc_regs dut_u (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .rx_byte_valid, .rx_byte, .rx_byte_last, .agc_auto_code,
        .gain_code_out, .hold_function_disable, .gain_force_max, .gain_loop_disable,
        .gain_hold_mode, .tx_ram_chip, .fsm_path_tx, .modulator_chip, .chip_source_select,
        .modulator_path_tx, .power_management_enable);

    // 100 mhz clock
    initial
    begin
        forever #5 pclk = ~pclk;
    end

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    task conclude;
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // derived outputs land one edge after the write edge; two edges are waited
    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task t_reset;
        apb(0, IDX_LAST_FRAME_LENGTH, 0);
        check("len_rst", rd, 32'h0);
        apb(0, IDX_GAIN_LOOP_CONTROL, 0);
        check("gain_rst", rd, 32'h0);
        apb(0, IDX_MODULATOR_OVERRIDE, 0);
        check("ovr_rst", rd, 32'h0);
    endtask : t_reset

    task t_gain;
        logic [7:0] w [5];
        logic [1:0] code;
        w = '{8'h00, 8'h0b, 8'h1b, 8'h24, 8'h09};
        // writes while power management is off must not act
        apb(1, IDX_GAIN_LOOP_CONTROL, 8'h3b);
        apb(0, IDX_GAIN_LOOP_CONTROL, 0);
        check("gain_pme_off", rd, 32'h0);
        check("loop_dis_off", gain_loop_disable, 0);
        apb(1, IDX_CTRL_ZERO, 8'h01);
        agc_auto_code <= 2'h2;
        for (int i = 0; i < 5; i++)
        begin
            apb(1, IDX_GAIN_LOOP_CONTROL, w[i]);
            settle();
            code = w[i][4] ? 2'h0 : (w[i][3] ? w[i][1:0] : 2'h2);
            check("gain_code", gain_code_out, code);
            check("pme_on", power_management_enable, 1'b1);
            check("gain_bits", {hold_function_disable, gain_force_max, gain_loop_disable,
                gain_hold_mode}, w[i][5:2]);
            apb(0, IDX_GAIN_LOOP_CONTROL, 0);
            check("gain_read", rd & 32'h3f, {w[i][5:2], code});
        end
        apb(1, IDX_CTRL_ZERO, 8'h00);
        settle();
        check("gain_revert", {gain_loop_disable, gain_code_out}, 3'h2);
        check("pme_off", power_management_enable, 1'b0);
    endtask : t_gain

    task t_ovr;
        logic [7:0] w [6];
        w = '{8'h00, 8'h80, 8'hc0, 8'h30, 8'h10, 8'h2f};
        apb(1, IDX_MODULATOR_OVERRIDE, 8'hf0);
        apb(0, IDX_MODULATOR_OVERRIDE, 0);
        check("ovr_pme_off", rd, 32'h0);
        apb(1, IDX_CTRL_ZERO, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            tx_ram_chip <= i[0];
            fsm_path_tx <= ~i[0];
            apb(1, IDX_MODULATOR_OVERRIDE, w[i]);
            settle();
            check("chip_src", chip_source_select, w[i][7]);
            check("chip", modulator_chip, w[i][7] ? w[i][6] : i[0]);
            check("path", modulator_path_tx, w[i][4] ? w[i][5] : !i[0]);
            apb(0, IDX_MODULATOR_OVERRIDE, 0);
            check("ovr_read", rd, {24'h0, w[i]});
        end
        apb(1, IDX_CTRL_ZERO, 8'h00);
    endtask : t_ovr

    task send_frame(input int k);
        for (int i = 0; i < k; i++)
        begin
            rx_byte_valid <= 1'b1;
            rx_byte <= 8'(i + 64);
            rx_byte_last <= (i == k - 1);
            @(posedge pclk);
        end
        rx_byte_valid <= 1'b0;
        rx_byte_last <= 1'b0;
    endtask : send_frame

    task t_frame;
        send_frame(128);
        apb(0, IDX_LAST_FRAME_LENGTH, 0);
        check("len128", rd, 32'h80);
        for (int n = 0; n < 128; n += 9)
        begin
            apb(0, IDX_FBUF_FIRST + 9'(n), 0);
            check("fbuf_byte", rd, 32'(n + 64));
        end
        apb(0, IDX_FBUF_LAST, 0);
        check("fbuf_last", rd, 32'hbf);
        apb(1, IDX_FBUF_FIRST, 8'h3c);
        apb(0, IDX_FBUF_FIRST, 0);
        check("fbuf_first", rd, 32'h3c);
        apb(1, IDX_FBUF_FIRST + 9'h2, 8'ha5);
        send_frame(2);
        apb(0, IDX_FBUF_FIRST + 9'h2, 0);
        check("len_not_stored", rd, 32'ha5);
        apb(0, IDX_FBUF_FIRST, 0);
        check("first_octet", rd, 32'h40);
        apb(1, IDX_LAST_FRAME_LENGTH, 8'h55);
        apb(0, IDX_LAST_FRAME_LENGTH, 0);
        check("len2", rd, 32'h2);
    endtask : t_frame

    // clock enable low: a whole frame must pass unseen
    task t_freeze;
        pce <= 1'b0;
        send_frame(3);
        pce <= 1'b1;
        apb(0, IDX_LAST_FRAME_LENGTH, 0);
        check("len_frozen", rd, 32'h2);
    endtask : t_freeze

    task t_unmapped;
        apb(0, 9'h100, 0);
        check("unmapped_err", err, 1'b1);
        check("unmapped_rd", rd, 32'h0);
    endtask : t_unmapped

    // main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gain();
        t_ovr();
        t_frame();
        t_freeze();
        t_unmapped();
        conclude();
    end
endmodule : testbench
